// file: logic/power_mode_and_reset_sequencer.v
// power mode controller and staged reset generator with apb register access
`timescale 1ns/1ps
`include "pwr_seq_regs.vh"
module power_mode_and_reset_sequencer #(
    parameter NPERIPH = 8
) (
    // clock and power-on reset (pclk is the oscillator clock)
    input  wire               pclk,
    input  wire               presetn,
    // apb slave
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire [11:0]        paddr,
    input  wire [31:0]        pwdata,
    output reg  [31:0]        prdata,
    output reg                pready,
    output reg                pslverr,
    // reset sources
    input  wire               ext_reset_n,
    input  wire               watchdog_timeout_reset,
    input  wire               watchdog_clock_loss_reset,
    // system clock cycle marker
    input  wire               sys_tick,
    // core and wake events
    input  wire               wait_exec,
    input  wire               stop_exec,
    input  wire               any_irq,
    input  wire               stop_irq,
    input  wire               low_voltage_irq,
    input  wire               debug_req,
    // resets out (active high)
    output reg                jtag_reset,
    output reg                clock_gen_reset,
    output reg                peripheral_reset,
    output reg                core_reset,
    // clock controls out
    output reg  [2:0]         mode,
    output reg                master_clk_en,
    output reg                core_clk_en,
    output reg                mem_clk_en,
    output reg                hs_clk_en,
    output reg  [NPERIPH-1:0] periph_clk_en,
    output reg                relaxation_source_select,
    output reg                pll_power_down,
    output reg                oscillator_standby,
    output reg                regulator_standby,
    output reg                oscillator_power_down,
    output reg                ext_standby_clk_sel,
    output reg                watchdog_tick
);

    localparam ST_RUN  = 2'd0;
    localparam ST_WAIT = 2'd1;
    localparam ST_STOP = 2'd2;

    wire               arst_n = presetn & ext_reset_n;
    reg  [6:0]         por_cnt_q;
    reg                por_str_q;
    reg                sw_rst_q;
    reg                wd_rst_q;
    reg  [1:0]         srst_cnt_q;
    reg                srst_q;
    reg  [5:0]         cg_cnt_q;
    reg                cg_q;
    reg  [5:0]         pr_cnt_q;
    reg                pr_q;
    reg  [5:0]         cr_cnt_q;
    reg                cr_q;
    reg  [6:0]         ctl_q;
    reg  [NPERIPH-1:0] stopdis_q;
    reg  [1:0]         st_q;
    reg  [1:0]         st_d;
    reg  [10:0]        wd_div_q;
    reg  [2:0]         mode_d;
    wire               comb = por_str_q | sw_rst_q | wd_rst_q;
    wire               standby = ctl_q[`CTL_RELAX_SEL_BIT] & ctl_q[`CTL_PLL_PD_BIT] &
                                 ctl_q[`CTL_OSC_STBY_BIT];
    wire               pdown = standby & ctl_q[`CTL_OSC_PD_BIT];
    wire               wr = psel & penable & pready & pwrite;

    // power-on stretcher, counts oscillator cycles, only presetn touches it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_cnt_q <= 7'h00;
            por_str_q <= 1'b1;
        end else if (por_str_q) begin
            por_cnt_q <= por_cnt_q + 7'h01;
            if (por_cnt_q == `POR_EXT_CYCLES - 7'h01) begin
                por_str_q <= 1'b0;
            end
        end
    end

    // synchronous reset generator for software and watchdog reset logic
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            srst_cnt_q <= 2'h0;
            srst_q     <= 1'b1;
        end else if (comb) begin
            srst_cnt_q <= 2'h0;
            srst_q     <= 1'b1;
        end else if (srst_q) begin
            srst_cnt_q <= srst_cnt_q + 2'h1;
            if (srst_cnt_q == `SYNC_RST_CYCLES - 2'h1) begin
                srst_q <= 1'b0;
            end
        end
    end

    // synchronous reset sources, latched until the reset generator clears them
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            sw_rst_q <= 1'b0;
            wd_rst_q <= 1'b0;
        end else if (srst_q) begin
            sw_rst_q <= 1'b0;
            wd_rst_q <= 1'b0;
        end else begin
            if (wr && paddr == `SYSCTL_OFS && pwdata[`CTL_SW_RESET_BIT]) begin
                sw_rst_q <= 1'b1;
            end
            if (watchdog_timeout_reset | watchdog_clock_loss_reset) begin
                wd_rst_q <= 1'b1;
            end
        end
    end

    // staged release: clock-gen on oscillator cycles, then two system-cycle stages
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            cg_cnt_q <= 6'h00;
            cg_q     <= 1'b1;
            pr_cnt_q <= 6'h00;
            pr_q     <= 1'b1;
            cr_cnt_q <= 6'h00;
            cr_q     <= 1'b1;
        end else if (comb) begin
            cg_cnt_q <= 6'h00;
            cg_q     <= 1'b1;
            pr_cnt_q <= 6'h00;
            pr_q     <= 1'b1;
            cr_cnt_q <= 6'h00;
            cr_q     <= 1'b1;
        end else begin
            if (cg_q) begin
                cg_cnt_q <= cg_cnt_q + 6'h01;
                if (cg_cnt_q == `CLKGEN_CYCLES - 6'h01) begin
                    cg_q <= 1'b0;
                end
            end else if (pr_q && sys_tick) begin
                pr_cnt_q <= pr_cnt_q + 6'h01;
                if (pr_cnt_q == `PERIPH_CYCLES - 6'h01) begin
                    pr_q <= 1'b0;
                end
            end else if (!pr_q && cr_q && sys_tick) begin
                cr_cnt_q <= cr_cnt_q + 6'h01;
                if (cr_cnt_q == `CORE_CYCLES - 6'h01) begin
                    cr_q <= 1'b0;
                end
            end
        end
    end

    // reset outputs change on the falling edge to avoid skew
    always @(negedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            clock_gen_reset  <= 1'b1;
            peripheral_reset <= 1'b1;
            core_reset       <= 1'b1;
        end else begin
            clock_gen_reset  <= cg_q | comb;
            peripheral_reset <= pr_q | comb;
            core_reset       <= cr_q | comb;
        end
    end

    always @(negedge pclk or negedge presetn) begin
        if (!presetn) begin
            jtag_reset <= 1'b1;
        end else begin
            jtag_reset <= 1'b0;
        end
    end

    // watchdog time base
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            wd_div_q      <= 11'h000;
            watchdog_tick <= 1'b0;
        end else if (comb) begin
            wd_div_q      <= 11'h000;
            watchdog_tick <= 1'b0;
        end else begin
            watchdog_tick <= (wd_div_q == `WDOG_DIV - 11'h001);
            if (wd_div_q == `WDOG_DIV - 11'h001) begin
                wd_div_q <= 11'h000;
            end else begin
                wd_div_q <= wd_div_q + 11'h001;
            end
        end
    end

    // apb registers
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            ctl_q     <= `CTL_RESET_VAL;
            stopdis_q <= {NPERIPH{1'b0}};
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
        end else if (comb) begin
            ctl_q     <= `CTL_RESET_VAL;
            stopdis_q <= {NPERIPH{1'b0}};
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            prdata    <= 32'h00000000;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & (paddr != `SYSCTL_OFS) &
                       (paddr != `STOPDIS_OFS) & (paddr != `STATUS_OFS);
            prdata  <= 32'h00000000;
            if (psel && !penable && !pwrite) begin
                case (paddr)
                    `SYSCTL_OFS:  prdata <= {25'h0000000, ctl_q[6:1], 1'b0};
                    `STOPDIS_OFS: prdata <= {{(32-NPERIPH){1'b0}}, stopdis_q};
                    `STATUS_OFS:  prdata <= {25'h0000000, cr_q, pr_q, cg_q, 1'b0, mode};
                    default:      prdata <= 32'h00000000;
                endcase
            end
            if (wr && paddr == `SYSCTL_OFS) begin
                ctl_q <= {pwdata[6:1], 1'b0};
            end
            if (wr && paddr == `STOPDIS_OFS) begin
                stopdis_q <= pwdata[NPERIPH-1:0];
            end
        end
    end

    // wait/stop state, usable also under standby clocking
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_RUN: begin
                if (!pdown && stop_exec) begin
                    st_d = ST_STOP;
                end else if (!pdown && wait_exec) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (any_irq | debug_req) begin
                    st_d = ST_RUN;
                end
            end
            ST_STOP: begin
                if (stop_irq | low_voltage_irq | debug_req) begin
                    st_d = ST_RUN;
                end
            end
            default: st_d = ST_RUN;
        endcase
        if (pdown) begin
            st_d = ST_RUN;
        end
        mode_d = `MODE_RUN;
        if (pdown) begin
            mode_d = `MODE_PDOWN;
        end else if (st_d == ST_WAIT) begin
            mode_d = `MODE_WAIT;
        end else if (st_d == ST_STOP) begin
            mode_d = `MODE_STOP;
        end else if (standby) begin
            mode_d = `MODE_STANDBY;
        end
    end

    // clock gates; reset of any source returns to run
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            st_q          <= ST_RUN;
            mode          <= `MODE_RUN;
            master_clk_en <= 1'b1;
            core_clk_en   <= 1'b1;
            mem_clk_en    <= 1'b1;
            hs_clk_en     <= 1'b1;
        end else if (comb) begin
            st_q          <= ST_RUN;
            mode          <= `MODE_RUN;
            master_clk_en <= 1'b1;
            core_clk_en   <= 1'b1;
            mem_clk_en    <= 1'b1;
            hs_clk_en     <= 1'b1;
        end else begin
            st_q          <= st_d;
            mode          <= mode_d;
            master_clk_en <= !pdown;
            core_clk_en   <= !pdown && st_d == ST_RUN;
            mem_clk_en    <= !pdown && st_d == ST_RUN;
            hs_clk_en     <= !standby && st_d != ST_STOP;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NPERIPH; gi = gi + 1) begin : g_pclk
            always @(posedge pclk or negedge arst_n) begin
                if (!arst_n) begin
                    periph_clk_en[gi] <= 1'b1;
                end else begin
                    periph_clk_en[gi] <= comb | (!pdown && (st_d != ST_STOP ||
                                         stopdis_q[gi]));
                end
            end
        end
    endgenerate

    // standby control pins driven from the control register
    always @(posedge pclk or negedge arst_n) begin
        if (!arst_n) begin
            relaxation_source_select <= 1'b0;
            pll_power_down           <= 1'b0;
            oscillator_standby       <= 1'b0;
            regulator_standby        <= 1'b0;
            oscillator_power_down    <= 1'b0;
            ext_standby_clk_sel      <= 1'b0;
        end else begin
            relaxation_source_select <= ctl_q[`CTL_RELAX_SEL_BIT];
            pll_power_down           <= ctl_q[`CTL_PLL_PD_BIT];
            oscillator_standby       <= ctl_q[`CTL_OSC_STBY_BIT];
            regulator_standby        <= ctl_q[`CTL_REG_STBY_BIT];
            oscillator_power_down    <= ctl_q[`CTL_OSC_PD_BIT];
            ext_standby_clk_sel      <= ctl_q[`CTL_EXT_CLK_BIT];
        end
    end

endmodule // power_mode_and_reset_sequencer

// file: logic/pwr_seq_regs.vh
// register offsets, fields, reset values and timing counts of the power and reset sequencer
`ifndef PWR_SEQ_REGS_VH
`define PWR_SEQ_REGS_VH

// register byte offsets
`define SYSCTL_OFS         12'h000
`define STOPDIS_OFS        12'h004
`define STATUS_OFS         12'h008

// system_control_reg fields
`define CTL_SW_RESET_BIT   0
`define CTL_RELAX_SEL_BIT  1
`define CTL_PLL_PD_BIT     2
`define CTL_OSC_STBY_BIT   3
`define CTL_REG_STBY_BIT   4
`define CTL_OSC_PD_BIT     5
`define CTL_EXT_CLK_BIT    6
`define CTL_RESET_VAL      7'h00

// status fields
`define STS_MODE_LSB       0
`define STS_CLKGEN_BIT     4
`define STS_PERIPH_BIT     5
`define STS_CORE_BIT       6

// mode codes
`define MODE_RUN           3'h0
`define MODE_WAIT          3'h1
`define MODE_STOP          3'h2
`define MODE_STANDBY       3'h3
`define MODE_PDOWN         3'h4

// timing counts
`define POR_EXT_CYCLES     7'h40
`define CLKGEN_CYCLES      6'h20
`define PERIPH_CYCLES      6'h20
`define CORE_CYCLES        6'h20
`define SYNC_RST_CYCLES    2'h3
`define WDOG_DIV           11'h400

`endif

// file: verif/core_model.sv
// behavioural core and clock source: system clock marker and sleep instructions
`timescale 1ns/1ps
module core_model (
    // clock and reset
    input  wire pclk,
    input  wire presetn,
    // core reset and bench requests
    input  wire core_reset,
    input  wire do_wait,
    input  wire do_stop,
    // to the sequencer
    output reg  sys_tick,
    output reg  wait_exec,
    output reg  stop_exec
);
    // system clock runs at half the oscillator rate
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sys_tick  <= 1'b0;
            wait_exec <= 1'b0;
            stop_exec <= 1'b0;
        end else begin
            sys_tick  <= ~sys_tick;
            wait_exec <= do_wait & ~core_reset;
            stop_exec <= do_stop & ~core_reset;
        end
    end
endmodule // core_model

// file: verif/power_mode_and_reset_sequencer_properties.sv
// port-level assertions for the power mode and reset sequencer
`timescale 1ns/1ps
`include "pwr_seq_regs.vh"
module seq_props #(
    parameter NPERIPH = 8
) (
    // clock and power-on reset
    input wire               pclk,
    input wire               presetn,
    // wake and reset events
    input wire               ext_reset_n,
    input wire               any_irq,
    input wire               stop_irq,
    input wire               low_voltage_irq,
    input wire               debug_req,
    // resets and clock gates
    input wire               jtag_reset,
    input wire               clock_gen_reset,
    input wire               peripheral_reset,
    input wire               core_reset,
    input wire [2:0]         mode,
    input wire               master_clk_en,
    input wire               core_clk_en,
    input wire               mem_clk_en,
    input wire               hs_clk_en,
    input wire [NPERIPH-1:0] periph_clk_en,
    input wire               watchdog_tick
);
    reg [10:0] gap_q;
    reg        seen_q;

    // cycles since the last tick; trusted only once a tick was seen outside reset
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_q  <= 11'h000;
            seen_q <= 1'b0;
        end else begin
            gap_q  <= watchdog_tick ? 11'h000 : gap_q + 11'h001;
            seen_q <= (seen_q | watchdog_tick) & ~clock_gen_reset;
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    jtag_hold_a: assert property (!jtag_reset |=> !jtag_reset)
        else $error("jtag reset reasserted");
    chain_order_a: assert property (!(clock_gen_reset && !peripheral_reset)
        && !(peripheral_reset && !core_reset)) else $error("reset stages out of order");
    ext_assert_a: assert property (!ext_reset_n |-> clock_gen_reset && core_reset)
        else $error("external reset not applied");
    run_clocks_a: assert property (mode == `MODE_RUN |-> core_clk_en && mem_clk_en
        && &periph_clk_en) else $error("run clocks off");
    wait_clocks_a: assert property (mode == `MODE_WAIT |-> !core_clk_en && !mem_clk_en
        && &periph_clk_en) else $error("wait clocks wrong");
    stop_clocks_a: assert property (mode == `MODE_STOP |-> master_clk_en && !core_clk_en
        && !mem_clk_en && !hs_clk_en) else $error("stop clocks wrong");
    pdown_off_a: assert property (mode == `MODE_PDOWN |-> !master_clk_en && !core_clk_en
        && !mem_clk_en && periph_clk_en == 0) else $error("power-down clocks on");
    wait_exit_a: assert property (mode == `MODE_WAIT && (any_irq || debug_req)
        |=> core_clk_en && mem_clk_en) else $error("wait not left");
    stop_exit_a: assert property (mode == `MODE_STOP && (stop_irq || low_voltage_irq
        || debug_req) |=> core_clk_en && mem_clk_en) else $error("stop not left");
    wdog_tick_a: assert property (watchdog_tick && seen_q |-> gap_q == 11'h3ff)
        else $error("watchdog tick spacing wrong");

    cover property (mode == `MODE_PDOWN);
    cover property ($fell(core_reset));
    cover property (mode == `MODE_STOP ##1 mode == `MODE_RUN);
    cover property (mode == `MODE_WAIT ##1 mode == `MODE_STANDBY);
endmodule // seq_props

bind power_mode_and_reset_sequencer seq_props #(.NPERIPH(NPERIPH)) props (.*);

// file: verif/power_mode_and_reset_sequencer_test.sv
// self-checking bench for the power mode and staged reset sequencer
`timescale 1ns/1ps
`include "pwr_seq_regs.vh"
module power_mode_and_reset_sequencer_test;
    reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h0;
    reg         ext_reset_n = 1'b1, watchdog_timeout_reset = 1'b0, watchdog_clock_loss_reset = 1'b0;
    reg         any_irq = 1'b0, stop_irq = 1'b0, low_voltage_irq = 1'b0, debug_req = 1'b0;
    reg         do_wait = 1'b0, do_stop = 1'b0, err;
    reg  [31:0] rd;
    wire [31:0] prdata;
    wire [2:0]  mode;
    wire [7:0]  periph_clk_en;
    wire        pready, pslverr, sys_tick, wait_exec, stop_exec, jtag_reset, clock_gen_reset;
    wire        peripheral_reset, core_reset, master_clk_en, core_clk_en, mem_clk_en, hs_clk_en;
    wire        relaxation_source_select, pll_power_down, oscillator_standby, regulator_standby;
    wire        oscillator_power_down, ext_standby_clk_sel, watchdog_tick;
    wire [5:0]  ctl_out = {ext_standby_clk_sel, oscillator_power_down, regulator_standby,
                           oscillator_standby, pll_power_down, relaxation_source_select};
    wire [2:0]  stages = {core_reset, peripheral_reset, clock_gen_reset};
    wire [12:0] gates = {mode, core_clk_en, mem_clk_en, periph_clk_en};
    integer     errors = 0, n_checks = 0, i, n;

    power_mode_and_reset_sequencer uut (.*);
    core_model partner (.*);

    always #25 pclk = ~pclk;

    task check(input string name, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("BAD %s expected %h seen %h", name, exp, seen);
            end
        end
    endtask

    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                @(posedge pclk);
            end
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask

    // one-cycle pulse on sleep requests and wake sources, then let it settle
    task pulse(input [5:0] v);
        begin
            {do_stop, do_wait, debug_req, low_voltage_irq, stop_irq, any_irq} <= v;
            @(posedge pclk);
            {do_stop, do_wait, debug_req, low_voltage_irq, stop_irq, any_irq} <= 6'h00;
            repeat (4) @(posedge pclk);
        end
    endtask

    // cycles until each stage releases, clock-gen first
    task chain(input integer lo);
        integer s, m;
        begin
            m = lo;
            for (s = 0; s < 3; s = s + 1) begin
                n = 0;
                while (stages[s] !== 1'b0 && n < 400) begin
                    @(posedge pclk);
                    n = n + 1;
                end
                check("release", n >= m && n <= m + 8, 1);
                m = 60;
            end
        end
    endtask

    task give_verdict;
        begin
            $display("checks %0d errors %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask

    initial begin
        repeat (10) @(posedge pclk);
        check("held", {jtag_reset, stages, gates}, {4'hf, `MODE_RUN, 10'h3ff});
        presetn <= 1'b1;
        chain(94);
        check("jtag", jtag_reset, 0);
        apb(0, `SYSCTL_OFS, 0);
        check("ctl", rd, 0);
        apb(1, `STOPDIS_OFS, 32'h0000_00a5);
        apb(1, `STATUS_OFS, 32'h0000_00ff);
        apb(0, `STOPDIS_OFS, 0);
        check("sdis", rd, 32'h0000_00a5);
        apb(0, `STATUS_OFS, 0);
        check("status", rd, 0);
        apb(1, 12'h00c, 32'hffff_ffff);
        check("unmapped", err, 1);
        for (i = 0; i < 2; i = i + 1) begin
            pulse(6'h10);
            check("wait", gates, {`MODE_WAIT, 10'h0ff});
            pulse(6'h01 << (3 * i));
            check("wake", mode, `MODE_RUN);
        end
        for (i = 1; i < 4; i = i + 1) begin
            pulse(6'h20);
            check("stop", {gates, master_clk_en, hs_clk_en}, {`MODE_STOP, 10'h0a5, 2'b10});
            pulse(6'h01);
            check("stay", mode, `MODE_STOP);
            pulse(6'h01 << i);
            check("wake", mode, `MODE_RUN);
        end
        for (i = 1; i < 5; i = i + 1)
            apb(1, `SYSCTL_OFS, (1 << (i + 1)) - 2);
        apb(1, `SYSCTL_OFS, 32'h0000_005e);
        pulse(6'h00);
        check("standby", {mode, hs_clk_en, ctl_out}, {`MODE_STANDBY, 1'b0, 6'h2f});
        pulse(6'h10);
        check("sb_wait", mode, `MODE_WAIT);
        pulse(6'h01);
        check("sb_wake", mode, `MODE_STANDBY);
        apb(1, `SYSCTL_OFS, 32'h0000_007e);
        pulse(6'h1f);
        check("pdown", {gates, master_clk_en, hs_clk_en}, {`MODE_PDOWN, 12'h000});
        ext_reset_n <= 1'b0;
        repeat (3) @(posedge pclk);
        check("ext", {jtag_reset, stages, mode}, {4'h7, `MODE_RUN});
        ext_reset_n <= 1'b1;
        chain(30);
        apb(0, `SYSCTL_OFS, 0);
        check("cleared", rd, 0);
        for (i = 0; i < 3; i = i + 1) begin
            if (i == 0)
                apb(1, `SYSCTL_OFS, 32'h0000_0001);
            else begin
                {watchdog_clock_loss_reset, watchdog_timeout_reset} <= i[1:0];
                @(posedge pclk);
                {watchdog_clock_loss_reset, watchdog_timeout_reset} <= 2'b00;
            end
            n = 0;
            while (clock_gen_reset !== 1'b1 && n < 8) begin
                @(posedge pclk);
                n = n + 1;
            end
            check("source", n < 8, 1);
            chain(30);
        end
        n = 0;
        while (watchdog_tick !== 1'b1 && n < 2100) begin
            @(posedge pclk);
            n = n + 1;
        end
        n = 0;
        @(posedge pclk);
        while (watchdog_tick !== 1'b1 && n < 2100) begin
            @(posedge pclk);
            n = n + 1;
        end
        check("tick", n, 1024 - 1);
        give_verdict;
    end

    // the tests need about 3000 cycles; allow about thirteen times that
    initial begin
        #2000000;
        errors = errors + 1;
        give_verdict;
    end
endmodule // power_mode_and_reset_sequencer_test
